// ===== pkg/afe_status_pkg.sv
package afe_status_pkg;

   // status word layout
   localparam int STAT_W          = 9;
   localparam int CFG_W           = 9;
   localparam int CFG_REGS        = 7;
   localparam int BIT_PARITY      = 0;
   localparam int BIT_ALARM       = 1;
   localparam int BIT_WAKE_X      = 2;
   localparam int BIT_WAKE_Y      = 3;
   localparam int BIT_WAKE_Z      = 4;
   localparam int BIT_AGC         = 5;
   localparam int BIT_ACT_X       = 6;
   localparam int BIT_ACT_Y       = 7;
   localparam int BIT_ACT_Z       = 8;
   localparam int COL_PARITY_IDX  = 6;
   localparam int CFG_ADDR_W      = 3;
   localparam logic [STAT_W-1:0] STAT_RESET = 9'h001;
   localparam logic [CFG_W-1:0]  CFG_RESET  = 9'h000;

   // live condition inputs from the analog side
   typedef struct packed {
      logic third_channel_active;
      logic second_channel_active;
      logic input_channel_active;
      logic gain_control_active;
      logic input_channel_woke;
      logic alarm_timeout;
      logic standby;
   } cond_type;

   // host command strobes, one cycle each
   typedef struct packed {
      logic                  status_read;
      logic                  sleep_cmd;
      logic                  soft_reset;
      logic                  cfg_write;
      logic [CFG_ADDR_W-1:0] cfg_addr;
      logic [CFG_W-1:0]      cfg_data;
      logic                  cfg_read;
   } cmd_type;

endpackage : afe_status_pkg

// ===== rtl/afe_status_and_config_parity.sv
`timescale 1ns/1ps
// What this block does
// [RULE1] power-on: status zero, parity flag set
// [RULE2] status read clears alarm flag only
// [RULE3] soft reset clears bits eight to two
// [RULE4] bits 8,7,4,3 are meaningless, ignored
// [RULE5] activity bits high passing data, low standby
// [RULE6] host writes row parity in bit 0
// [RULE7] host writes odd column parity, register six
// [RULE8] each config word holds odd ones; only words 0 to 5 are checked, word 6 is not
// [RULE9] parity error sets status bit 0
// [RULE10] alarm time-out sets status bit 1
module afe_status_and_config_parity (
   // clock and reset
   input  wire logic                                 I_CLK_SYS,
   input  wire logic                                 I_RST,
   // analog-side conditions, asynchronous
   input  wire afe_status_pkg::cond_type             I_COND,
   // host commands, same clock
   input  wire afe_status_pkg::cmd_type              I_CMD,
   // read data
   output logic [afe_status_pkg::STAT_W-1:0]         O_STATUS,
   output logic [afe_status_pkg::CFG_W-1:0]          O_CFG_RDATA,
   output logic                                      O_PARITY_FAULT
);

   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      afe_status_pkg::cond_type                                  sync1;
      afe_status_pkg::cond_type                                  sync2;
      logic                                                      alarm_prev;
      logic [afe_status_pkg::STAT_W-1:0]                         stat;
      logic [afe_status_pkg::CFG_REGS-1:0][afe_status_pkg::CFG_W-1:0] cfg;
      logic [afe_status_pkg::CFG_W-1:0]                          rdata;
   } state_type;

   state_type state_q;
   state_type state_d;
   // per-row and per-column parity results
   logic [afe_status_pkg::COL_PARITY_IDX-1:0]                    row_odd;
   logic [afe_status_pkg::CFG_W-1:0]                             col_odd;
   logic                                                         row_bad;
   logic                                                         col_bad;

   // word decode, storage and readback path
   logic [afe_status_pkg::CFG_REGS-1:0]                          word_sel;
   logic [afe_status_pkg::CFG_REGS:0][afe_status_pkg::CFG_W-1:0] read_chain;
   logic [afe_status_pkg::CFG_W-1:0]                             read_word;
   logic                                                         addr_ok;
   logic                                                         write_en;

   // decoded conditions
   afe_status_pkg::cond_type                                     cond_s;
   logic                                                         act_level;
   logic                                                         agc_level;
   logic                                                         wake_hold;
   logic                                                         alarm_edge;

   // next value of every status field
   logic                                                         act_z_next;
   logic                                                         act_y_next;
   logic                                                         act_x_next;
   logic                                                         agc_next;
   logic                                                         wake_z_next;
   logic                                                         wake_y_next;
   logic                                                         wake_x_next;
   logic                                                         alarm_next;
   logic                                                         parity_next;
   logic [afe_status_pkg::STAT_W-1:0]                            stat_next;

   ////////////////////////////////////////////////////////////////////////////////
   // row parity: each of words 0 to 5 must hold an odd count of ones
   genvar r;
   generate
      for (r = 0; r < afe_status_pkg::COL_PARITY_IDX; r++) begin : g_row
         assign row_odd[r] = ^state_q.cfg[r]; // [RULE6] [RULE8]
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // column parity: the parity word makes every bit column odd
   genvar c;
   generate
      for (c = 0; c < afe_status_pkg::CFG_W; c++) begin : g_col
         logic [afe_status_pkg::CFG_REGS-1:0] column;
         for (genvar k = 0; k < afe_status_pkg::CFG_REGS; k++) begin : g_bit
            assign column[k] = state_q.cfg[k][c];
         end
         assign col_odd[c] = ^column; // [RULE7]
      end
   endgenerate

   // real time, not sticky: a later good write clears the flag again
   assign row_bad = ~(&row_odd);
   assign col_bad = ~(&col_odd);

   ////////////////////////////////////////////////////////////////////////////////
   // one select line per stored word; address seven matches none of them
   genvar w;
   generate
      for (w = 0; w < afe_status_pkg::CFG_REGS; w++) begin : g_word
         assign word_sel[w]     = I_CMD.cfg_addr == 3'(w);
         assign read_chain[w+1] = read_chain[w] | (word_sel[w] ? state_q.cfg[w] : '0);
      end
   endgenerate

   assign read_chain[0] = '0;
   assign read_word     = read_chain[afe_status_pkg::CFG_REGS];
   // dropping the unmapped address avoids aliasing a real word
   assign addr_ok       = |word_sel;
   assign write_en      = I_CMD.cfg_write & addr_ok;

   ////////////////////////////////////////////////////////////////////////////////
   // decoded conditions, all from the second synchroniser stage
   assign cond_s     = state_q.sync2;
   assign act_level  = cond_s.input_channel_active & ~cond_s.standby; // [RULE5]
   assign agc_level  = cond_s.gain_control_active;
   assign wake_hold  = cond_s.input_channel_woke | state_q.stat[afe_status_pkg::BIT_WAKE_X];
   assign alarm_edge = cond_s.alarm_timeout & ~state_q.alarm_prev; // [RULE10]

   ////////////////////////////////////////////////////////////////////////////////
   // activity and gain control: live levels, cleared for a cycle by soft reset
   assign act_z_next  = 1'b0; // [RULE4]
   assign act_y_next  = 1'b0; // [RULE4]
   assign act_x_next  = act_level & ~I_CMD.soft_reset; // [RULE3]
   assign agc_next    = agc_level & ~I_CMD.soft_reset; // [RULE3]

   // wake source holds until a soft reset or a reset
   assign wake_z_next = 1'b0; // [RULE4]
   assign wake_y_next = 1'b0; // [RULE4]
   assign wake_x_next = wake_hold & ~I_CMD.soft_reset; // [RULE3]

   // a status read clears the alarm; a new time-out in the same cycle wins
   assign alarm_next = alarm_edge // [RULE10]
                     | (state_q.stat[afe_status_pkg::BIT_ALARM] & ~I_CMD.status_read); // [RULE2]

   // real-time parity indicator
   assign parity_next = row_bad | col_bad; // [RULE9]

   // assembled word; alarm and parity ignore soft reset, sleep changes nothing
   assign stat_next[afe_status_pkg::BIT_ACT_Z]  = act_z_next;
   assign stat_next[afe_status_pkg::BIT_ACT_Y]  = act_y_next;
   assign stat_next[afe_status_pkg::BIT_ACT_X]  = act_x_next;
   assign stat_next[afe_status_pkg::BIT_AGC]    = agc_next;
   assign stat_next[afe_status_pkg::BIT_WAKE_Z] = wake_z_next;
   assign stat_next[afe_status_pkg::BIT_WAKE_Y] = wake_y_next;
   assign stat_next[afe_status_pkg::BIT_WAKE_X] = wake_x_next;
   assign stat_next[afe_status_pkg::BIT_ALARM]  = alarm_next;
   assign stat_next[afe_status_pkg::BIT_PARITY] = parity_next;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;

      // two-stage synchroniser for the analog-side levels
      state_d.sync1      = I_COND;
      state_d.sync2      = state_q.sync1;
      state_d.alarm_prev = state_q.sync2.alarm_timeout;

      // configuration store
      if (write_en) begin
         state_d.cfg[I_CMD.cfg_addr] = I_CMD.cfg_data;
      end

      // readback; the unmapped address reads zero
      if (I_CMD.cfg_read) begin
         state_d.rdata = read_word;
      end

      // status word
      state_d.stat = stat_next;

      // synchronous reset overrides every update of this cycle
      if (I_RST) begin
         state_d      = '0;
         state_d.stat = afe_status_pkg::STAT_RESET; // [RULE1]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // every register of the block lives in state_q
   always_ff @(posedge I_CLK_SYS) begin
      state_q <= state_d;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register
   assign O_STATUS       = state_q.stat;
   assign O_CFG_RDATA    = state_q.rdata;
   assign O_PARITY_FAULT = state_q.stat[afe_status_pkg::BIT_PARITY];

endmodule : afe_status_and_config_parity

// ===== sim/afe_host_model.sv
`timescale 1ns/1ps
module afe_host_model (
   input  wire logic [47:0] i_data,
   output logic      [62:0] o_words
);
   always_comb begin
      for (int r = 0; r < 6; r++)
         o_words[r*9 +: 9] = {i_data[r*8 +: 8], ~^i_data[r*8 +: 8]};
      for (int c = 0; c < 9; c++) begin
         o_words[54+c] = 1'b1;
         for (int r = 0; r < 6; r++)
            o_words[54+c] ^= o_words[r*9+c];
      end
   end
endmodule : afe_host_model

// ===== sim/afe_status_checker.sv
`timescale 1ns/1ps
module afe_status_checker (
   input wire logic                     I_CLK_SYS,
   input wire logic                     I_RST,
   input wire afe_status_pkg::cond_type I_COND,
   input wire afe_status_pkg::cmd_type  I_CMD,
   input wire logic [8:0]               O_STATUS,
   input wire logic                     O_PARITY_FAULT
);
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);
   // a read racing a fresh alarm edge may lose, so only quiet reads count
   sequence s_read;
      I_CMD.status_read && !(|{I_COND.alarm_timeout, $past(I_COND.alarm_timeout, 2)});
   endsequence
   sequence s_idle; I_COND.standby [*4]; endsequence
   property p_por; $fell(I_RST) |-> O_STATUS == 9'h001; endproperty
   a_por: assert property (p_por) else $error("reset value");
   property p_read; s_read |=> !O_STATUS[1]; endproperty
   a_read: assert property (p_read) else $error("alarm kept");
   property p_soft; I_CMD.soft_reset |=> O_STATUS[8:2] == 7'h00; endproperty
   a_soft: assert property (p_soft) else $error("soft reset");
   property p_void; O_STATUS[8:7] == 2'h0 && O_STATUS[4:3] == 2'h0; endproperty
   a_void: assert property (p_void) else $error("unused bits");
   property p_idle; s_idle |-> !O_STATUS[6]; endproperty
   a_idle: assert property (p_idle) else $error("standby activity");
   property p_pf; O_PARITY_FAULT == O_STATUS[0]; endproperty
   a_pf: assert property (p_pf) else $error("fault mismatch");
   property p_alarm; $rose(I_COND.alarm_timeout) |-> ##3 O_STATUS[1]; endproperty
   a_alarm: assert property (p_alarm) else $error("alarm missed");
endmodule : afe_status_checker
bind afe_status_and_config_parity afe_status_checker i_afe_status_checker (.I_CLK_SYS,
   .I_RST, .I_COND, .I_CMD, .O_STATUS, .O_PARITY_FAULT);

// ===== sim/afe_status_and_config_parity_tb.sv
`timescale 1ns/1ps
module afe_status_and_config_parity_tb;
   logic clk = 1'b0, rst = 1'b1, fault;
   afe_status_pkg::cond_type cond = '0;
   afe_status_pkg::cmd_type cmd = '0;
   logic [8:0] st, rd;
   logic [47:0] data;
   logic [62:0] w;
   int fail_count = 0, check_count = 0;
   always #25 clk = ~clk;
   afe_status_and_config_parity i_afe_status_and_config_parity (.I_CLK_SYS(clk), .I_RST(rst),
      .I_COND(cond), .I_CMD(cmd), .O_STATUS(st), .O_CFG_RDATA(rd), .O_PARITY_FAULT(fault));
   afe_host_model i_afe_host_model (.i_data(data), .o_words(w));
   task automatic tick(int n); repeat (n) @(posedge clk); #1; endtask : tick
   // back-to-back strobes keep cmd up so it is never assigned twice in one step
   task automatic send(afe_status_pkg::cmd_type c, bit last = 1'b1);
      cmd = c;
      tick(1);
      if (last) cmd = '0;
   endtask : send
   // odd row parity over words 0..5, odd column parity over words 0..6
   function automatic logic exp_fault(logic [62:0] v);
      logic bad, col;
      bad = 1'b0;
      for (int r = 0; r < 6; r++) bad |= ~^v[r*9 +: 9];
      for (int c = 0; c < 9; c++) begin
         col = 1'b0;
         for (int r = 0; r < 7; r++) col ^= v[r*9+c];
         bad |= ~col;
      end
      return bad;
   endfunction : exp_fault
   task automatic check(string s, logic [8:0] e, logic [8:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", s, e, g);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude
   initial begin
      void'($urandom(32'hCA8B));
      tick(5);
      check("reset", 9'h001, st);
      rst = 1'b0;
      repeat (4) begin
         data = 48'({$urandom, $urandom});
         tick(1);
         for (int r = 0; r < 7; r++) begin
            send('{cfg_write: 1'b1, cfg_addr: 3'(r), cfg_data: w[r*9 +: 9], default: '0}, r == 6);
         end
         tick(2);
         check("good", {8'h00, exp_fault(w)}, {8'h00, fault});
         send('{cfg_write: 1'b1, cfg_addr: 3'h2, cfg_data: w[18 +: 9] ^ 9'h010, default: '0});
         tick(2);
         check("bad", {8'h00, exp_fault(w ^ (63'h1 << 22))}, {8'h00, fault});
      end
      send('{cfg_read: 1'b1, default: '0});
      tick(1);
      check("readback", w[8:0], rd);
      cond.alarm_timeout = 1'b1;
      cond.input_channel_woke = 1'b1;
      tick(4);
      check("alarm", 9'h007, st & 9'h007);
      cond = '0;
      tick(3);
      send('{status_read: 1'b1, default: '0});
      check("read", 9'h005, st & 9'h007);
      cond.input_channel_active = 1'b1;
      cond.gain_control_active = 1'b1;
      cond.second_channel_active = 1'b1;
      cond.alarm_timeout = 1'b1;
      tick(4);
      check("active", 9'h067, st);
      send('{soft_reset: 1'b1, default: '0});
      check("soft", 9'h003, st);
      cond.standby = 1'b1;
      tick(4);
      check("standby", 9'h001, st & 9'h041);
      conclude();
   end
   initial begin
      #100us;
      fail_count++;
      conclude();
   end
endmodule : afe_status_and_config_parity_tb
